// ==== common/ucpm_pkg.sv ====
// Purpose: Shared constants, enums and carriers for the charge port mode
//          controller.
// Assumes: One 25 MHz system clock, synchronous active-low reset.
// Notes:   Analog comparator results arrive as logic levels.
package ucpm_pkg;

	// ==========================================================
	// Clock and timing
	localparam longint unsigned CLK_HZ   = 64'd25_000_000;
	localparam longint unsigned REARM_US = 64'd100;
	// Least time, rounded up to whole cycles
	localparam longint unsigned REARM_CYC =
		(REARM_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] REARM_CNT = CNT_W'(REARM_CYC);
	localparam logic [CNT_W-1:0] CNT_RST   = 12'h000;

	// ==========================================================
	// Register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	localparam int CTRL_FORCE_OFF_BIT = 0;
	localparam logic CTRL_FORCE_OFF_RST = 1'b0;
	localparam int STAT_MODE_LSB  = 0;
	localparam int STAT_CDP_LSB   = 4;
	localparam int STAT_DCP_LSB   = 8;
	localparam int STAT_OVP_BIT   = 12;
	localparam int STAT_POWER_BIT = 13;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ==========================================================
	// Modes and states
	typedef enum logic [2:0] {
		MODE_OFF   = 3'h0,
		MODE_HS    = 3'h1,
		MODE_CDP   = 3'h2,
		MODE_DCP2A = 3'h3,
		MODE_DCP1A = 3'h4
	} ucpm_mode_t;

	typedef enum logic [1:0] {
		CDP_IDLE  = 2'h0,
		CDP_ARMED = 2'h1,
		CDP_DRIVE = 2'h2,
		CDP_WAIT  = 2'h3
	} ucpm_cdp_t;

	typedef enum logic [1:0] {
		DCP_IDLE  = 2'h0,
		DCP_BIAS  = 2'h1,
		DCP_SHORT = 2'h2
	} ucpm_dcp_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic in_good;
		logic mode_select_upper;
		logic mode_select_lower;
		logic ovp_any;
		logic vbus_present;
		logic dp_high;
		logic dm_high;
		logic dp_low;
		logic dm_low;
		logic cdp_cmp_hit;
		logic dm_ok_2a;
		logic dp_ok_2a;
		logic dm_ok_1a;
		logic dp_ok_1a;
	} ucpm_sense_t;

	localparam int SYNC_W = $bits(ucpm_sense_t);

	typedef struct packed {
		logic power_enable;
		logic pass_switch_ctl;
		logic emulation_switch_ctl;
		logic auto_detect_enable;
		logic host_port_detect_enable;
		logic cdp_sw3_ctl;
		logic cdp_sw4_ctl;
		logic cmp_pos_force_zero;
		logic bias_2a_ctl;
		logic bias_1a_ctl;
		logic line_short_switch;
	} ucpm_sw_t;

	localparam ucpm_sw_t SW_RST = '0;

endpackage : ucpm_pkg

// ==== rtl/ucpm_sync.sv ====
// Purpose: Two-flop synchroniser for all sensed inputs.
// Assumes: Inputs may change at any time relative to mclk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module ucpm_sync (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic [ucpm_pkg::SYNC_W-1:0] d_in,
	output var  logic [ucpm_pkg::SYNC_W-1:0] d_out
);
	import ucpm_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] stable;
	} ucpm_sync_st_t;

	ucpm_sync_st_t st_ff;
	ucpm_sync_st_t nxt_st;

	// ==========================================================
	// Two stages
	always_comb begin
		nxt_st.meta   = d_in;
		nxt_st.stable = st_ff.meta;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign d_out = st_ff.stable;

	// ==========================================================
	// Checks
	// two-cycle latency
	a_sync_latency: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(rst_n, 2) |-> d_out == $past(d_in, 2))
		else $error("synchroniser latency is not two cycles");

endmodule : ucpm_sync

`default_nettype wire

// ==== rtl/ucpm_ctrl.sv ====
// Purpose: Mode decode, charging downstream port handshake and dedicated
//          charger auto detection for the protected data lines.
// Assumes: Comparator results and mode pins are logic levels; 25 MHz mclk.
// Notes:   Avalon-MM slave with waitrequest holds control and status.
`timescale 1ns/1ps
`default_nettype none

module ucpm_ctrl (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire ucpm_pkg::ucpm_sense_t       sense_in,
	input  wire logic [ucpm_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	output var  logic [31:0]                 avs_readdata,
	output var  logic                        avs_waitrequest,
	output var  ucpm_pkg::ucpm_sw_t          sw_out
);
	import ucpm_pkg::*;

	typedef struct packed {
		ucpm_mode_t       mode;
		ucpm_cdp_t        cdp;
		logic [CNT_W-1:0] cnt;
		ucpm_dcp_t        dcp;
		logic             gate_off;
		logic             force_off;
		logic             waitreq;
		logic [31:0]      rdata;
		ucpm_sw_t         sw;
	} ucpm_st_t;

	localparam ucpm_st_t ST_RST = '{
		mode:      MODE_OFF,
		cdp:       CDP_IDLE,
		cnt:       CNT_RST,
		dcp:       DCP_IDLE,
		gate_off:  1'b1,
		force_off: CTRL_FORCE_OFF_RST,
		waitreq:   1'b1,
		rdata:     RDATA_RST,
		sw:        SW_RST
	};

	ucpm_st_t    st_ff;
	ucpm_st_t    nxt_st;
	ucpm_sense_t sn;
	logic        lines_low;
	logic        line_high;
	logic        prof_ok;
	logic        is_auto;

	// ==========================================================
	// Functions
	function automatic ucpm_mode_t decode_mode(input logic good,
		input logic upper, input logic lower);
		ucpm_mode_t m;
		m = MODE_OFF;
		if (good) begin
			case ({upper, lower})
				2'b00:   m = MODE_HS;
				2'b01:   m = MODE_CDP;
				2'b10:   m = MODE_DCP2A;
				2'b11:   m = MODE_DCP1A;
				default: m = MODE_OFF;
			endcase
		end
		return m;
	endfunction : decode_mode

	function automatic logic [31:0] status_word(input ucpm_st_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[STAT_MODE_LSB +: 3] = s.mode;
		w[STAT_CDP_LSB +: 2]  = s.cdp;
		w[STAT_DCP_LSB +: 2]  = s.dcp;
		w[STAT_OVP_BIT]       = s.gate_off;
		w[STAT_POWER_BIT]     = s.sw.power_enable;
		return w;
	endfunction : status_word

	// ==========================================================
	// Input synchroniser
	// all sensed inputs
	ucpm_sync u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.d_in  (sense_in),
		.d_out (sn)
	);

	// ==========================================================
	// Next state
	always_comb begin
		nxt_st    = st_ff;
		lines_low = sn.dp_low && sn.dm_low;
		line_high = sn.dp_high || sn.dm_high;
		nxt_st.mode = decode_mode(sn.in_good, sn.mode_select_upper,
			sn.mode_select_lower);
		is_auto = (nxt_st.mode == MODE_DCP2A) ||
			(nxt_st.mode == MODE_DCP1A);
		prof_ok = (nxt_st.mode == MODE_DCP2A) ?
			(sn.dm_ok_2a && sn.dp_ok_2a) : (sn.dm_ok_1a && sn.dp_ok_1a);
		nxt_st.gate_off = sn.ovp_any || st_ff.force_off ||
			(nxt_st.mode == MODE_OFF);

		// Handshake sequencer
		if (nxt_st.mode != MODE_CDP) begin
			nxt_st.cdp = CDP_IDLE;
			nxt_st.cnt = CNT_RST;
		end else begin
			case (st_ff.cdp)
				CDP_IDLE: begin
					// arm only with both lines low
					nxt_st.cdp = lines_low ? CDP_ARMED : CDP_WAIT;
					nxt_st.cnt = CNT_RST;
				end
				CDP_ARMED: begin
					if (line_high) begin
						nxt_st.cdp = CDP_WAIT;
						nxt_st.cnt = CNT_RST;
					end else if (sn.cdp_cmp_hit) begin
						nxt_st.cdp = CDP_DRIVE;
					end
				end
				CDP_DRIVE: begin
					if (line_high) begin
						nxt_st.cdp = CDP_WAIT;
						nxt_st.cnt = CNT_RST;
					end else if (!sn.cdp_cmp_hit) begin
						nxt_st.cdp = CDP_ARMED;
					end
				end
				CDP_WAIT: begin
					if (!lines_low) begin
						nxt_st.cnt = CNT_RST;
					end else if (st_ff.cnt == REARM_CNT) begin
						nxt_st.cdp = CDP_ARMED;
						nxt_st.cnt = CNT_RST;
					end else begin
						nxt_st.cnt = st_ff.cnt + 1'b1;
					end
				end
				default: begin
					nxt_st.cdp = CDP_IDLE;
					nxt_st.cnt = CNT_RST;
				end
			endcase
		end

		// Auto detection
		if (!is_auto) begin
			nxt_st.dcp = DCP_IDLE;
		end else if (nxt_st.mode != st_ff.mode) begin
			nxt_st.dcp = DCP_BIAS;
		end else begin
			case (st_ff.dcp)
				DCP_IDLE: nxt_st.dcp = DCP_BIAS;
				DCP_BIAS: begin
					if (!prof_ok) begin
						nxt_st.dcp = DCP_SHORT;
					end
				end
				DCP_SHORT: begin
					if (!sn.vbus_present) begin
						nxt_st.dcp = DCP_BIAS;
					end
				end
				default: nxt_st.dcp = DCP_IDLE;
			endcase
		end

		// Switch outputs
		nxt_st.sw = SW_RST;
		nxt_st.sw.power_enable = !sn.ovp_any && !st_ff.force_off;
		if (!nxt_st.gate_off) begin
			nxt_st.sw.pass_switch_ctl = (nxt_st.mode == MODE_HS) ||
				(nxt_st.mode == MODE_CDP);
			nxt_st.sw.emulation_switch_ctl    = is_auto;
			nxt_st.sw.auto_detect_enable      = is_auto;
			nxt_st.sw.host_port_detect_enable = (nxt_st.mode == MODE_CDP);
			nxt_st.sw.cdp_sw3_ctl = (nxt_st.cdp == CDP_ARMED) ||
				(nxt_st.cdp == CDP_DRIVE);
			nxt_st.sw.cdp_sw4_ctl        = (nxt_st.cdp == CDP_DRIVE);
			nxt_st.sw.cmp_pos_force_zero = (nxt_st.cdp == CDP_WAIT);
			nxt_st.sw.bias_2a_ctl = (nxt_st.dcp == DCP_BIAS) &&
				(nxt_st.mode == MODE_DCP2A);
			nxt_st.sw.bias_1a_ctl = (nxt_st.dcp == DCP_BIAS) &&
				(nxt_st.mode == MODE_DCP1A);
			nxt_st.sw.line_short_switch = (nxt_st.dcp == DCP_SHORT);
		end

		// Avalon slave: one wait state, then acknowledge
		nxt_st.waitreq = 1'b1;
		if ((avs_read || avs_write) && st_ff.waitreq) begin
			nxt_st.waitreq = 1'b0;
			nxt_st.rdata   = RDATA_RST;
			if (avs_read && avs_address == CTRL_OFS) begin
				nxt_st.rdata[CTRL_FORCE_OFF_BIT] = st_ff.force_off;
			end else if (avs_read && avs_address == STAT_OFS) begin
				nxt_st.rdata = status_word(st_ff);
			end
		end
		if (avs_write && !st_ff.waitreq && avs_address == CTRL_OFS) begin
			nxt_st.force_off = avs_writedata[CTRL_FORCE_OFF_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sw_out          = st_ff.sw;
	assign avs_readdata    = st_ff.rdata;
	assign avs_waitrequest = st_ff.waitreq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_good_low_off: assert property (!sn.in_good |=>
		!sw_out.pass_switch_ctl && !sw_out.emulation_switch_ctl)
		else $error("data switch closed with input-good low");

	// select 10 gives 2.1A auto detection
	a_sel_2a_map: assert property (sn.in_good && sn.mode_select_upper &&
		!sn.mode_select_lower && !sn.ovp_any && !st_ff.force_off |=>
		sw_out.emulation_switch_ctl && !sw_out.pass_switch_ctl &&
		sw_out.auto_detect_enable && !sw_out.host_port_detect_enable)
		else $error("select 10 decode wrong");

	// both selects high use 1.0A profile
	a_sel_1a_map: assert property (sn.in_good && sn.mode_select_upper &&
		sn.mode_select_lower && !sn.ovp_any && !st_ff.force_off |=>
		sw_out.emulation_switch_ctl && !sw_out.pass_switch_ctl &&
		sw_out.auto_detect_enable && !sw_out.host_port_detect_enable &&
		!sw_out.bias_2a_ctl)
		else $error("select 11 decode wrong");

	a_hs_no_detect: assert property (st_ff.mode == MODE_HS |->
		!sw_out.cdp_sw3_ctl && !sw_out.cdp_sw4_ctl &&
		!sw_out.host_port_detect_enable && !sw_out.cmp_pos_force_zero &&
		(sw_out.pass_switch_ctl || st_ff.gate_off))
		else $error("detection active in high-speed mode");

	a_cdp_armed_sw3: assert property (st_ff.cdp == CDP_ARMED &&
		!st_ff.gate_off |-> sw_out.cdp_sw3_ctl &&
		sw_out.host_port_detect_enable)
		else $error("armed without switch 3");

	// switch 4 only rises after a comparator hit
	a_sw4_cause: assert property ($rose(sw_out.cdp_sw4_ctl) |->
		$past(sn.cdp_cmp_hit))
		else $error("switch 4 closed without comparator hit");

	// positive line high opens switches 3 and 4
	a_dp_high_open: assert property (sn.dp_high |=>
		!sw_out.cdp_sw3_ctl && !sw_out.cdp_sw4_ctl)
		else $error("switch 3 or 4 closed with line high");

	// re-arm only after the full low count
	a_rearm_delay: assert property ($past(st_ff.cdp) == CDP_WAIT &&
		st_ff.cdp == CDP_ARMED |-> $past(st_ff.cnt) == REARM_CNT)
		else $error("switch 3 re-closed early");

	a_entry_2a_bias: assert property ($changed(st_ff.mode) &&
		st_ff.mode == MODE_DCP2A && !st_ff.gate_off |->
		sw_out.bias_2a_ctl && !sw_out.pass_switch_ctl)
		else $error("2.1A entry without divider");

	a_entry_1a_bias: assert property ($changed(st_ff.mode) &&
		st_ff.mode == MODE_DCP1A && !st_ff.gate_off |->
		sw_out.bias_1a_ctl && !sw_out.pass_switch_ctl)
		else $error("1.0A entry without divider");

	a_bias_hold: assert property (st_ff.dcp == DCP_BIAS && prof_ok &&
		nxt_st.mode == st_ff.mode |=> st_ff.dcp == DCP_BIAS)
		else $error("divider dropped with thresholds met");

	a_short_on_fail: assert property (st_ff.dcp == DCP_BIAS && !prof_ok &&
		nxt_st.mode == st_ff.mode |=> st_ff.dcp == DCP_SHORT)
		else $error("no short after threshold broken");

	// supply removal restarts on the divider
	a_short_release: assert property (st_ff.dcp == DCP_SHORT &&
		!sn.vbus_present && nxt_st.mode == st_ff.mode |=>
		st_ff.dcp == DCP_BIAS ##0 !sw_out.line_short_switch)
		else $error("short not released on supply removal");

	// overvoltage opens power and data switches
	a_ovp_all_off: assert property (sn.ovp_any |=>
		sw_out == SW_RST)
		else $error("switch closed during overvoltage");

	a_bus_ack: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus request not acknowledged in one cycle");

	c_cdp_rearm: cover property ($past(st_ff.cdp) == CDP_WAIT &&
		st_ff.cdp == CDP_ARMED);
	c_cdp_drive: cover property (st_ff.cdp == CDP_DRIVE);
	c_dcp_short: cover property (st_ff.dcp == DCP_SHORT ##1
		st_ff.dcp == DCP_BIAS);
	c_ovp_hit:   cover property ($rose(sn.ovp_any));

endmodule : ucpm_ctrl

`default_nettype wire

// ==== sim/ucpm_dev_model.sv ====
// Purpose: Portable device on the protected lines, seen as line levels.
// Assumes: act picks what the device does; sw is the block's switch set.
// Notes:   Host-side sense fields are left at 0 for the bench to merge.
`timescale 1ns/1ps
`default_nettype none

module ucpm_dev_model (
	input  wire logic [2:0]            act,
	input  wire ucpm_pkg::ucpm_sw_t    sw,
	output var  ucpm_pkg::ucpm_sense_t lines
);
	import ucpm_pkg::*;

	// ==========================================================
	// Line levels
	always_comb begin
		lines = '0;
		lines.dp_low  = !(act == 3'h2 || act == 3'h5);
		lines.dp_high = !lines.dp_low;
		lines.dm_high = (act == 3'h3);
		lines.dm_low  = !lines.dm_high;
		// probe level, lost once comparator input is zeroed
		lines.cdp_cmp_hit = (act == 3'h1) && !sw.cmp_pos_force_zero;
		lines.dm_ok_2a = (act != 3'h4);
		lines.dm_ok_1a = (act != 3'h4);
		lines.dp_ok_2a = (act != 3'h5);
		lines.dp_ok_1a = (act != 3'h5);
	end

endmodule : ucpm_dev_model

`default_nettype wire

// ==== sim/ucpm_ctrl_tb.sv ====
// Purpose: Self-checking bench for the charge port mode controller.
// Assumes: 25 MHz mclk, synchronous active-low reset.
// Notes:   Sense input merges host drive with the device model.
`timescale 1ns/1ps
`default_nettype none

module ucpm_ctrl_tb;
	import ucpm_pkg::*;

	logic              mclk;
	logic              rst_n;
	ucpm_sense_t       host;
	ucpm_sense_t       lines;
	ucpm_sense_t       sense_in;
	logic [2:0]        act;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	ucpm_sw_t          sw_out;
	logic [31:0]       rd;
	int                bad_count;
	int                cmp_count;
	logic [3:0]        dec;
	logic [4:0]        cdp;
	logic [2:0]        dcp;
	logic [3:0]        msk;
	logic [4:0]        hv [5] = '{5'h01, 5'h11, 5'h15, 5'h19, 5'h1d};
	logic [3:0]        ev [5] = '{4'h0, 4'h8, 4'h9, 4'h6, 4'h6};

	assign sense_in = ucpm_sense_t'(host | lines);
	assign dec = {sw_out.pass_switch_ctl, sw_out.emulation_switch_ctl,
		sw_out.auto_detect_enable, sw_out.host_port_detect_enable};
	assign cdp = {sw_out.pass_switch_ctl, sw_out.host_port_detect_enable,
		sw_out.cdp_sw3_ctl, sw_out.cdp_sw4_ctl, sw_out.cmp_pos_force_zero};
	assign dcp = {sw_out.bias_2a_ctl, sw_out.bias_1a_ctl,
		sw_out.line_short_switch};

	ucpm_ctrl u_ucpm_ctrl (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.sense_in        (sense_in),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.sw_out          (sw_out)
	);

	ucpm_dev_model u_ucpm_dev_model (
		.act   (act),
		.sw    (sw_out),
		.lines (lines)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ==========================================================
	// Tasks
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wait_n

	task automatic drive(input logic [4:0] h, input logic [2:0] a);
		@(posedge mclk);
		host <= ucpm_sense_t'({h, 9'h000});
		act  <= a;
	endtask : drive

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !w;
		avs_write     <= w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// Take edge plus one wait state
		chk("bus_wait", 32'h2, 32'(n));
	endtask : bus

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Tests
	initial begin
		rst_n = 1'b0;
		host = '0;
		act = 3'h0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		bad_count = 0;
		cmp_count = 0;
		wait_n(8);
		chk("sw_rst", 32'(SW_RST), 32'(sw_out));
		chk("rd_rst", RDATA_RST, avs_readdata);
		@(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl_rst", 32'(CTRL_FORCE_OFF_RST), rd);
		$display("Test reset finished");

		for (int i = 0; i < 5; i++) begin
			msk = (i == 0) ? 4'hc : 4'hf;
			drive(hv[i], 3'h0);
			wait_n(4);
			chk("decode", 32'(ev[i] & msk), 32'(dec & msk));
		end
		$display("Test decode finished");

		for (int k = 0; k < 2; k++) begin
			drive(k ? 5'h1d : 5'h19, 3'h0);
			wait_n(4);
			chk("dcp_entry", k ? 32'h2 : 32'h4, 32'(dcp));
			wait_n(50);
			chk("dcp_keep", k ? 32'h2 : 32'h4, 32'(dcp));
			drive(k ? 5'h1d : 5'h19, k ? 3'h5 : 3'h4);
			wait_n(4);
			chk("dcp_short", 32'h1, 32'(dcp));
			drive(k ? 5'h1c : 5'h18, 3'h0);
			wait_n(4);
			chk("dcp_again", k ? 32'h2 : 32'h4, 32'(dcp));
		end
		$display("Test dcp finished");

		drive(5'h15, 3'h0);
		wait_n(6);
		chk("cdp_arm", 32'h1c, 32'(cdp));
		drive(5'h15, 3'h1);
		wait_n(4);
		chk("cdp_hit", 32'h1e, 32'(cdp));
		drive(5'h15, 3'h2);
		wait_n(4);
		chk("cdp_high", 32'h19, 32'(cdp));
		drive(5'h15, 3'h0);
		wait_n(1500);
		drive(5'h15, 3'h3);
		wait_n(10);
		drive(5'h15, 3'h0);
		wait_n(int'(REARM_CNT) - 100);
		chk("sw3_hold", 32'h0, 32'(sw_out.cdp_sw3_ctl));
		wait_n(200);
		chk("sw3_rearm", 32'h1, 32'(sw_out.cdp_sw3_ctl));
		drive(5'h15, 3'h1);
		wait_n(4);
		drive(5'h11, 3'h1);
		wait_n(4);
		chk("hs_off", 32'h10, 32'(cdp));
		drive(5'h15, 3'h0);
		wait_n(4);
		chk("cdp_back", 32'h1, 32'(sw_out.cdp_sw3_ctl));
		$display("Test cdp finished");

		drive(5'h11, 3'h0);
		wait_n(4);
		drive(5'h13, 3'h0);
		wait_n(2);
		chk("ovp_sync", 32'h1, 32'(sw_out.power_enable));
		wait_n(1);
		chk("ovp_off", 32'h0, 32'(sw_out));
		drive(5'h11, 3'h0);
		wait_n(4);
		chk("ovp_clear", 32'h3, 32'(sw_out[10:9]));
		bus(1'b1, CTRL_OFS, 32'h1);
		bus(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl_rw", 32'h1, rd);
		wait_n(4);
		chk("force_off", 32'h0, 32'(sw_out[10:9]));
		bus(1'b0, STAT_OFS, 32'h0);
		chk("status", 32'h1001, rd & 32'h3007);
		bus(1'b1, CTRL_OFS, 32'h0);
		bus(1'b1, 4'h8, 32'hffff_ffff);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("Test ovp_regs finished");
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		stop_test();
	end

endmodule : ucpm_ctrl_tb

`default_nettype wire
